//--- rtl/dsc_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH
`define DSC_ADDR_PWRDN 8'h01
`define DSC_ADDR_CAL_CLK_SEL 8'h0e
`define DSC_ADDR_CALSTAT 8'h0f
`define DSC_ADDR_COEF_ADDR 8'h10
`define DSC_ADDR_COEF_DATA 8'h11
`define DSC_ADDR_CALCMD 8'h12
`define DSC_BIT_EXT_REF_SEL 0
`define DSC_BIT_CLKEN 3
`define DSC_BIT_SELI 4
`define DSC_BIT_SELQ 5
`define DSC_BIT_DONEI 6
`define DSC_BIT_DONEQ 7
`define DSC_BIT_Q_UNCAL 0
`define DSC_BIT_I_UNCAL 1
`define DSC_BIT_MEMRD 2
`define DSC_BIT_MEMWR 3
`define DSC_BIT_START 4
`define DSC_RST_REG 8'h00
`define DSC_DIV_MIN_LOG2 5
`define DSC_CAL_CYCLES 16'd300
`define DSC_NUM_COEF 32
`endif

//--- rtl/dsc_pkg.sv
// Shared types for the calibration control block
package dsc_pkg;
  typedef logic [7:0] dsc_byte_t;
  typedef enum logic [2:0] {
    DSC_IDLE = 3'b001,
    DSC_RUN = 3'b010,
    DSC_DONE = 3'b100
  } dsc_state_e;
endpackage

//--- rtl/dsc_cal_engine.sv
// One channel's self-calibration engine
`timescale 1ns/10ps
`default_nettype none
`include "dsc_defs.svh"
module dsc_cal_engine #(
  parameter int CAL_CYCLES = `DSC_CAL_CYCLES
) (
  input wire logic clk, // Converter clock
  input wire logic srst, // Synchronous reset
  input wire logic cal_tick, // One pulse per calibration clock period
  input wire logic run, // Start bit and core select together
  output logic done // Calibration finished
);
  // ----------------------------------------------------------------
  // Engine sequence
  // ----------------------------------------------------------------
  dsc_pkg::dsc_state_e state_q;
  logic [15:0] cnt_q;

  // Counts calibration clock periods; leaving run always restarts
  // status clears on restart
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      state_q <= dsc_pkg::DSC_IDLE;
      cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        dsc_pkg::DSC_IDLE: begin
          state_q <= dsc_pkg::DSC_RUN;
          cnt_q <= 16'h0000;
        end
        dsc_pkg::DSC_RUN: begin
          if (cal_tick) begin
            if (cnt_q == 16'(CAL_CYCLES - 1)) begin
              state_q <= dsc_pkg::DSC_DONE;
            end
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        dsc_pkg::DSC_DONE: state_q <= dsc_pkg::DSC_DONE;
        default: state_q <= dsc_pkg::DSC_IDLE;
      endcase
    end
  end

  assign done = (state_q == dsc_pkg::DSC_DONE);
endmodule
`default_nettype wire

//--- rtl/dsc_top.sv
// Converter reference select, self-calibration control and code mapping
`timescale 1ns/10ps
`default_nettype none
`include "dsc_defs.svh"
module dsc_top #(
  parameter int CODE_W = 14,
  parameter int NUM_COEF = `DSC_NUM_COEF,
  parameter int CAL_CYCLES = `DSC_CAL_CYCLES
) (
  input wire logic clk, // Converter clock, 20 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Register write data
  output logic [7:0] reg_rdata, // Register read data
  input wire logic [CODE_W-1:0] i_code, // I channel input code
  input wire logic [CODE_W-1:0] q_code, // Q channel input code
  output logic external_reference_select, // Internal reference off
  output logic cal_clock_out, // Divided calibration clock level
  output logic [CODE_W-1:0] i_positive_output, // I positive drive
  output logic [CODE_W-1:0] i_negative_output, // I negative drive
  output logic [CODE_W-1:0] q_positive_output, // Q positive drive
  output logic [CODE_W-1:0] q_negative_output // Q negative drive
);
  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic pwrdn_q;
  logic [7:0] clksel_q;
  logic [7:0] cmd_q;
  logic [4:0] coef_addr_q;
  logic [5:0] coef_i_q [NUM_COEF];
  logic [5:0] coef_q_q [NUM_COEF];
  logic i_done, q_done;
  logic [2:0] cal_divider_select;
  logic cal_clock_enable, i_cal_core_select, q_cal_core_select;
  logic cal_start, coef_mem_read_enable, coef_mem_write_enable;
  logic i_uncalibrate, q_uncalibrate;

  assign cal_divider_select = clksel_q[2:0];
  assign cal_clock_enable = clksel_q[`DSC_BIT_CLKEN];
  assign i_cal_core_select = clksel_q[`DSC_BIT_SELI];
  assign q_cal_core_select = clksel_q[`DSC_BIT_SELQ];
  assign cal_start = cmd_q[`DSC_BIT_START];
  assign coef_mem_read_enable = cmd_q[`DSC_BIT_MEMRD];
  assign coef_mem_write_enable = cmd_q[`DSC_BIT_MEMWR];
  assign i_uncalibrate = cmd_q[`DSC_BIT_I_UNCAL];
  assign q_uncalibrate = cmd_q[`DSC_BIT_Q_UNCAL];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  always_ff @(posedge clk) begin
    if (srst) begin
      pwrdn_q <= 1'b0;
    end else if (reg_wr && hit(reg_addr, `DSC_ADDR_PWRDN)) begin
      pwrdn_q <= reg_wdata[`DSC_BIT_EXT_REF_SEL];
    end
  end
  assign external_reference_select = pwrdn_q;

  // Clock select: divider, clock gate, core selects
  // core select bits
  always_ff @(posedge clk) begin
    if (srst) begin
      clksel_q <= `DSC_RST_REG;
    end else if (reg_wr && hit(reg_addr, `DSC_ADDR_CAL_CLK_SEL)) begin
      clksel_q <= {2'b00, reg_wdata[5:0]};
    end
  end

  // Command register; a write of 0x00 clears everything including
  // the uncalibrate bits
  // uncalibrate cleared by write
  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_q <= `DSC_RST_REG;
    end else if (reg_wr && hit(reg_addr, `DSC_ADDR_CALCMD)) begin
      cmd_q <= {3'b000, reg_wdata[4:0]};
    end
  end

  // Coefficient address, five bits cover the 32 entries
  always_ff @(posedge clk) begin
    if (srst) begin
      coef_addr_q <= 5'h00;
    end else if (reg_wr && hit(reg_addr, `DSC_ADDR_COEF_ADDR)) begin
      coef_addr_q <= reg_wdata[4:0];
    end
  end

  // ----------------------------------------------------------------
  // Calibration clock divider
  // ----------------------------------------------------------------
  // Divide by 2^(5+sel): 32 up to 2048 counts; sel 7 saturates at 2048
  // so the period never leaves the documented span.
  logic [10:0] div_cnt_q;
  logic [10:0] div_last;
  logic cal_tick;
  logic cal_clk_q;

  function automatic logic [10:0] div_len(input logic [2:0] sel);
    logic [3:0] sh;
    sh = (sel > 3'd6) ? 4'd11 : 4'(sel) + 4'd`DSC_DIV_MIN_LOG2;
    return 11'((12'h001 << sh) - 12'h001);
  endfunction

  assign div_last = div_len(cal_divider_select);
  assign cal_tick = cal_clock_enable && (div_cnt_q == div_last);

  always_ff @(posedge clk) begin
    if (srst || !cal_clock_enable) begin
      div_cnt_q <= 11'h000;
      cal_clk_q <= 1'b0;
    end else begin
      div_cnt_q <= (div_cnt_q >= div_last) ? 11'h000 : div_cnt_q + 11'h001;
      cal_clk_q <= (div_cnt_q < {1'b0, div_last[10:1]}) ? 1'b1 : 1'b0;
    end
  end
  assign cal_clock_out = cal_clk_q;

  // ----------------------------------------------------------------
  // Per-channel engines
  // ----------------------------------------------------------------
  // independent engines
  dsc_cal_engine #(.CAL_CYCLES(CAL_CYCLES)) u_eng_i (
    .clk(clk),
    .srst(srst),
    .cal_tick(cal_tick),
    .run(cal_start && i_cal_core_select),
    .done(i_done)
  );
  dsc_cal_engine #(.CAL_CYCLES(CAL_CYCLES)) u_eng_q (
    .clk(clk),
    .srst(srst),
    .cal_tick(cal_tick),
    .run(cal_start && q_cal_core_select),
    .done(q_done)
  );

  // ----------------------------------------------------------------
  // Coefficient memories
  // ----------------------------------------------------------------
  // Writes land in every selected core, so both may be loaded at once.
  // Engines themselves do not rewrite coefficients here; the analog
  // trim result is outside this logic.
  // coefficient storage
  always_ff @(posedge clk) begin
    if (reg_wr && coef_mem_write_enable &&
        hit(reg_addr, `DSC_ADDR_COEF_DATA)) begin
      if (i_cal_core_select) begin
        coef_i_q[coef_addr_q] <= reg_wdata[5:0];
      end
      if (q_cal_core_select) begin
        coef_q_q[coef_addr_q] <= reg_wdata[5:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register readback
  // ----------------------------------------------------------------
  // Reads return a registered value one cycle after the strobe
  // status bits
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `DSC_ADDR_PWRDN: reg_rdata <= {7'h00, pwrdn_q};
        `DSC_ADDR_CAL_CLK_SEL: reg_rdata <= clksel_q;
        `DSC_ADDR_CALSTAT: reg_rdata <= {q_done, i_done, 6'h00};
        `DSC_ADDR_COEF_ADDR: reg_rdata <= {3'b000, coef_addr_q};
        `DSC_ADDR_COEF_DATA: begin
          if (!coef_mem_read_enable) begin
            reg_rdata <= 8'h00;
          end else if (i_cal_core_select) begin
            reg_rdata <= {2'b00, coef_i_q[coef_addr_q]};
          end else if (q_cal_core_select) begin
            reg_rdata <= {2'b00, coef_q_q[coef_addr_q]};
          end else begin
            reg_rdata <= 8'h00;
          end
        end
        `DSC_ADDR_CALCMD: begin
          reg_rdata <= {cmd_q[7:2], i_uncalibrate, q_uncalibrate};
        end
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Code mapping
  // ----------------------------------------------------------------
  // complementary outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      i_positive_output <= '0;
      i_negative_output <= '0;
      q_positive_output <= '0;
      q_negative_output <= '0;
    end else begin
      i_positive_output <= i_code;
      i_negative_output <= ~i_code;
      q_positive_output <= q_code;
      q_negative_output <= ~q_code;
    end
  end
endmodule
`default_nettype wire

//--- tb/dsc_top_monitor.sv
// Port-level assertions for the calibration control block
`timescale 1ns/10ps
`default_nettype none
module dsc_top_monitor #(
  parameter int CODE_W = 14
) (
  input wire logic clk, // Clock
  input wire logic srst, // Reset
  input wire logic reg_wr, // Write
  input wire logic reg_rd, // Read
  input wire logic [7:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Wdata
  input wire logic [7:0] reg_rdata, // Rdata
  input wire logic [CODE_W-1:0] i_code, // I code
  input wire logic [CODE_W-1:0] q_code, // Q code
  input wire logic external_reference_select, // Ref off
  input wire logic cal_clock_out, // Cal clock
  input wire logic [CODE_W-1:0] i_positive_output, // I pos
  input wire logic [CODE_W-1:0] i_negative_output, // I neg
  input wire logic [CODE_W-1:0] q_positive_output, // Q pos
  input wire logic [CODE_W-1:0] q_negative_output // Q neg
);
  // ------------
  // Mirrors
  // ------------
  logic en_q, rden_q, seen_q, prev_q;
  logic [11:0] cnt_q;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Gate and read-enable bits as last written
  always_ff @(posedge clk) begin
    if (srst) begin
      en_q <= 1'b0;
      rden_q <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h0e) begin
      en_q <= reg_wdata[3];
    end else if (reg_wr && reg_addr == 8'h12) begin
      rden_q <= reg_wdata[2];
    end
  end
  // Cycles since the last cal clock rise
  always_ff @(posedge clk) begin
    prev_q <= cal_clock_out;
    if (srst || !en_q || (cal_clock_out && !prev_q)) cnt_q <= 12'h000;
    else if (cnt_q != 12'hfff) cnt_q <= cnt_q + 12'h001;
  end
  // First rise after enabling may come early, so it is not timed
  always_ff @(posedge clk) begin
    if (srst || !en_q) seen_q <= 1'b0;
    else if (cal_clock_out && !prev_q) seen_q <= 1'b1;
  end
  ref_sel_a: assert property (
    reg_wr && reg_addr == 8'h01 ##1 !(reg_wr && reg_addr == 8'h01)
    |=> {7'h00, external_reference_select} == ($past(reg_wdata, 2) & 8'h01))
    else $error("reference select does not follow its bit");
  pwrdn_read_a: assert property (
    reg_rd && !reg_wr && reg_addr == 8'h01
    |=> reg_rdata[0] == external_reference_select)
    else $error("reference bit reads back wrong");
  i_code_map_a: assert property (
    !$past(srst) |-> i_positive_output == $past(i_code)
    && i_negative_output == ~$past(i_code))
    else $error("I outputs do not map the code");
  q_code_map_a: assert property (
    !$past(srst) |-> q_positive_output == $past(q_code)
    && q_negative_output == ~$past(q_code))
    else $error("Q outputs do not map the code");
  cal_gate_a: assert property (
    !en_q [*3] |-> !cal_clock_out)
    else $error("cal clock runs with gate off");
  cal_period_a: assert property (
    cal_clock_out && !prev_q && seen_q |-> cnt_q >= 12'd31
    && cnt_q <= 12'd2047)
    else $error("cal clock period out of range");
  done_clear_a: assert property (
    reg_wr && reg_addr == 8'h12 && !reg_wdata[4] ##1 !reg_wr
    ##1 (reg_rd && !reg_wr && reg_addr == 8'h0f) |=> reg_rdata[7:6] == 2'b00)
    else $error("done bits stay after stop");
  coef_refuse_a: assert property (
    reg_rd && reg_addr == 8'h11 && !rden_q |=> reg_rdata == 8'h00)
    else $error("coefficient read without enable");
endmodule
`default_nettype wire

//--- tb/dsc_top_tb.sv
// Self-checking bench for the calibration control block
`timescale 1ns/10ps
`default_nettype none
module dsc_top_tb;
  // ------------
  // Stimulus
  // ------------
  logic clk, srst, reg_wr, reg_rd, ext_ref, cal_clk;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [13:0] i_code, q_code, ip, ineg, qp, qn, cc;
  logic [13:0] cv [3] = '{14'h3fff, 14'h0000, 14'h1a5c};
  logic [7:0] cm [3] = '{8'h18, 8'h28, 8'h38};
  int failures, tests_run, n;
  dsc_top #(.CAL_CYCLES(3)) dut (.clk(clk), .srst(srst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .i_code(i_code), .q_code(q_code),
    .external_reference_select(ext_ref), .cal_clock_out(cal_clk),
    .i_positive_output(ip), .i_negative_output(ineg),
    .q_positive_output(qp), .q_negative_output(qn));
  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Strobes last one cycle, so back-to-back calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Plain read, value left in d; polling uses it without comparing
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(d, e);
  endtask
  task automatic wait_lvl(input logic lv);
    while (cal_clk !== lv && n < 5000) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  // Edges from here to the next cal clock rise, bounded
  task automatic rise();
    n = 0;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    if (n >= 5000) begin
      failures++;
      results();
    end
  endtask
  initial begin
    failures = 0;
    tests_run = 0;
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    i_code = 14'h0000;
    q_code = 14'h0000;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rc(8'h01, 8'h00);
    wr(8'h13, 8'hff);
    rc(8'h13, 8'h00);
    wr(8'h01, 8'h01);
    rc(8'h01, 8'h01);
    chk(ext_ref, 1'b1);
    wr(8'h01, 8'h00);
    rc(8'h01, 8'h00);
    chk(ext_ref, 1'b0);
    $display("test reference done");
    foreach (cv[k]) begin
      @(posedge clk);
      i_code <= cv[k];
      q_code <= ~cv[k];
      cc = ~cv[k];
      repeat (2) @(posedge clk);
      #1 chk(ip, cv[k]);
      chk(ineg, cc);
      chk(qp, cc);
      chk(qn, cv[k]);
    end
    $display("test code map done");
    wr(8'h12, 8'hef);
    rc(8'h12, 8'h0f);
    wr(8'h12, 8'h00);
    rc(8'h12, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr(8'h0e, 8'h00);
      wr(8'h0e, 8'h08 | 8'(s));
      rise();
      rise();
      chk(16'(n), s > 5 ? 16'd2048 : 16'd32 << s);
    end
    wr(8'h0e, 8'h00);
    repeat (3) @(posedge clk);
    repeat (64) begin
      @(posedge clk);
      #1 chk(cal_clk, 1'b0);
    end
    $display("test cal clock done");
    // One, the other, then both engines; the idle engine must stay clear
    foreach (cm[k]) begin
      wr(8'h12, 8'h00);
      wr(8'h0e, cm[k]);
      wr(8'h12, 8'h10);
      rc(8'h0f, 8'h00);
      n = 0;
      d = 8'h00;
      while (d !== {cm[k][5:4], 6'h00} && n < 100) begin
        rd(8'h0f);
        n++;
      end
      chk(d, {cm[k][5:4], 6'h00});
      if (n >= 100) results();
      chk(16'(n > 25), 16'h0001);
      wr(8'h12, 8'h00);
      rc(8'h0f, 8'h00);
      wr(8'h0e, 8'h00);
    end
    $display("test calibration done");
    for (int c = 0; c < 2; c++) begin
      wr(8'h0e, c ? 8'h20 : 8'h10);
      wr(8'h12, 8'h08);
      for (int a = 0; a < 32; a++) begin
        wr(8'h10, 8'(a));
        wr(8'h11, 8'(a) ^ (c ? 8'h3f : 8'h15));
      end
    end
    wr(8'h12, 8'h00);
    wr(8'h11, 8'h2a);
    rc(8'h11, 8'h00);
    wr(8'h12, 8'h04);
    for (int c = 0; c < 2; c++) begin
      wr(8'h0e, c ? 8'h20 : 8'h10);
      for (int a = 0; a < 32; a++) begin
        wr(8'h10, 8'(a));
        rc(8'h11, 8'(a) ^ (c ? 8'h3f : 8'h15));
      end
    end
    wr(8'h12, 8'h00);
    $display("test coefficients done");
    results();
  end
endmodule
bind dsc_top dsc_top_monitor #(.CODE_W(CODE_W)) mon (.clk(clk),
  .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .i_code(i_code),
  .q_code(q_code), .external_reference_select(external_reference_select),
  .cal_clock_out(cal_clock_out), .i_positive_output(i_positive_output),
  .i_negative_output(i_negative_output),
  .q_positive_output(q_positive_output),
  .q_negative_output(q_negative_output));
`default_nettype wire
